/* File: src/gyro_readout_consts.svh */
`ifndef GYRO_READOUT_CONSTS_SVH
`define GYRO_READOUT_CONSTS_SVH

// Register offsets
`define OFS_IDENT 8'h00
`define OFS_RATE_X_LOW 8'h02
`define OFS_RATE_X_HIGH 8'h03
`define OFS_RATE_Y_LOW 8'h04
`define OFS_RATE_Y_HIGH 8'h05
`define OFS_RATE_Z_LOW 8'h06
`define OFS_RATE_Z_HIGH 8'h07
`define OFS_INT_FLAGS 8'h0a
`define OFS_QUEUE_FILL 8'h0e
`define OFS_FULL_SCALE 8'h0f
`define OFS_FILTER_RATE 8'h10
`define OFS_POWER_STATE 8'h11
`define OFS_RESTART 8'h14
`define OFS_INT_ENABLES 8'h15
`define OFS_IRQ_PIN_ELEC 8'h16
`define OFS_FIFO_CFG_1 8'h3e

// Field positions
`define BIT_DRDY 7
`define BIT_FIFO_INT 4
`define BIT_OVERRUN 7
`define BIT_DATA_EN 7
`define BIT_FIFO_EN 6

// Reset values and codes
`define RST_FULL_SCALE 8'h00
`define RST_FILTER_RATE 8'h80
`define FILTER_RATE_RO_MASK 8'h80
`define RST_POWER_STATE 8'h00
`define RST_INT_ENABLES 8'h00
`define INT_ENABLES_MASK 8'hc0
`define RST_IRQ_PIN_ELEC 8'h0f
`define IRQ_PIN_ELEC_MASK 8'h0f
`define RESTART_KEY 8'hb6
`define IDENT_VALUE_DEFAULT 8'h5a

// Timing
`define CLK_PERIOD_PS 5000
`define DRDY_HOLD_MIN_US 280
`define DRDY_HOLD_CYCLES ((`DRDY_HOLD_MIN_US * 1000000) / `CLK_PERIOD_PS)
`define RESTART_DELAY_MS 30
// Cycles per ms worked out first so the product stays inside 32 bits
`define CYCLES_PER_MS (1000000000 / `CLK_PERIOD_PS)
`define RESTART_DELAY_CYCLES (`RESTART_DELAY_MS * `CYCLES_PER_MS)

`endif

/* File: src/gyro_readout_pkg.sv */
package gyro_readout_pkg;

  typedef enum logic [1:0] {axis_x, axis_y, axis_z} axis_e;

  typedef struct packed {
    logic [15:0] x;
    logic [15:0] y;
    logic [15:0] z;
  } rate_set_s;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } reg_req_s;

  typedef struct packed {
    logic [7:0] full_scale;
    logic [7:0] filter_rate;
    logic [7:0] power_state;
    logic [7:0] int_enables;
    logic [7:0] irq_pin_elec;
  } cfg_s;

  typedef struct packed {
    cfg_s cfg;
    logic [2:0][7:0] high_hold;
    logic [2:0] high_locked;
    rate_set_s shown;
    logic drdy;
    logic [31:0] drdy_cnt;
    logic fifo_int;
    logic overrun;
    logic [6:0] frames;
    logic restart_pend;
    logic [31:0] restart_cnt;
    logic [7:0] rdata;
  } state_s;

endpackage : gyro_readout_pkg

/* File: src/gyro_register_readout.sv */
// What this block does
// R1 - Read-only 8-bit identification register sits at offset zero.
// R2 - Each axis rate is signed 16-bit, low byte register then high byte.
// R3 - Host builds value as high times 256 plus low; X,Y,Z from 0x02.
// R4 - Reading a low byte freezes its high byte until that high is read.
// R5 - Range code zero maps plus or minus 32767 counts to 2000 dps.
// R6 - Status bit 7 is data ready, bit 4 FIFO; ready self-clears 280-400 us.
// R7 - FIFO status bit 7 is overrun, cleared only by FIFO config 1 write.
// R8 - FIFO status bits 6..0 give stored frame count, zero when empty.
// R9 - Frame count clears when all frames read or config 1 written.
// R10 - Enable bit 7 gates new-data interrupt, bit 6 FIFO; both reset zero.
// R11 - Writing 0xB6 to restart resets configuration after 30 ms.
// R12 - Reserved bits and reserved offsets read zero without side effects.
// R13 - Samples during a freeze update internals, shown after high is read.
`timescale 1ns/1ps
`include "gyro_readout_consts.svh"

module gyro_register_readout #(
  parameter logic [7:0] IDENT_VALUE = `IDENT_VALUE_DEFAULT, // Arbitrary value
  parameter int unsigned DRDY_HOLD = `DRDY_HOLD_CYCLES,
  parameter int unsigned RESTART_DELAY = `RESTART_DELAY_CYCLES
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic arst_n,
  // Register access
  input wire gyro_readout_pkg::reg_req_s req,
  output logic [7:0] rdata,
  // Sample source
  input wire logic sample_valid,
  input wire gyro_readout_pkg::rate_set_s sample,
  // FIFO side events
  input wire logic fifo_event,
  input wire logic fifo_overrun_event,
  input wire logic fifo_frame_push,
  input wire logic fifo_frame_pop,
  // Configuration seen by the sensor core
  output gyro_readout_pkg::cfg_s cfg,
  output logic fifo_config_clear
);

  gyro_readout_pkg::state_s st_r;
  gyro_readout_pkg::state_s st_nxt;
  gyro_readout_pkg::rate_set_s latest_r;
  logic [2:0][15:0] latest_v;
  logic [2:0][15:0] shown_v;
  logic cfg1_wr;
  logic [2:0] low_rd;
  logic [2:0] high_rd;

  // Latest sample kept internally so a freeze never loses it
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      latest_r <= '0;
    end else if (sample_valid) begin
      latest_r <= sample; // see R5
    end
  end

  assign latest_v = {latest_r.x, latest_r.y, latest_r.z};
  assign shown_v = {st_r.shown.x, st_r.shown.y, st_r.shown.z};
  assign cfg1_wr = req.wr && req.addr == `OFS_FIFO_CFG_1;

  genvar g;
  generate
    for (g = 0; g < 3; g++) begin : g_axis
      // Index 2 is X, 1 is Y, 0 is Z
      assign low_rd[g] = req.rd &&
        req.addr == 8'(`OFS_RATE_X_LOW + 2 * (2 - g));
      assign high_rd[g] = req.rd &&
        req.addr == 8'(`OFS_RATE_X_HIGH + 2 * (2 - g));
    end
  endgenerate

  always_comb begin
    logic [2:0][15:0] sh;
    sh = shown_v;
    st_nxt = st_r;
    // Shown copy follows latest per axis unless its high byte is frozen
    for (int i = 0; i < 3; i++) begin
      if (!st_r.high_locked[i]) begin
        sh[i] = latest_v[i]; // see R13
      end
      if (low_rd[i]) begin
        st_nxt.high_locked[i] = 1'b1; // see R4
        st_nxt.high_hold[i] = shown_v[i][15:8];
      end else if (high_rd[i]) begin
        st_nxt.high_locked[i] = 1'b0; // see R4
      end
    end
    st_nxt.shown = {sh[2], sh[1], sh[0]};

    // Data ready: set on a sample, self-clears after hold time
    if (sample_valid) begin
      st_nxt.drdy = 1'b1;
      st_nxt.drdy_cnt = '0;
    end else if (st_r.drdy) begin
      if (st_r.drdy_cnt >= DRDY_HOLD - 1) begin
        st_nxt.drdy = 1'b0; // see R6
      end else begin
        st_nxt.drdy_cnt = st_r.drdy_cnt + 32'h1;
      end
    end

    // FIFO interrupt status follows the core's event level
    st_nxt.fifo_int = fifo_event; // see R6

    // Overrun sticky; set wins over clear
    if (fifo_overrun_event) begin
      st_nxt.overrun = 1'b1; // see R7
    end else if (cfg1_wr) begin
      st_nxt.overrun = 1'b0; // see R7
    end

    // Frame counter, saturates at 127
    if (cfg1_wr) begin
      st_nxt.frames = '0; // see R9
    end else if (fifo_frame_push && !fifo_frame_pop) begin
      if (st_r.frames != 7'h7f) begin
        st_nxt.frames = st_r.frames + 7'h1; // see R8
      end
    end else if (fifo_frame_pop && !fifo_frame_push) begin
      if (st_r.frames != 7'h00) begin
        st_nxt.frames = st_r.frames - 7'h1; // see R9
      end
    end

    // Configuration writes
    if (req.wr) begin
      unique case (req.addr)
        `OFS_FULL_SCALE: st_nxt.cfg.full_scale = req.wdata;
        `OFS_FILTER_RATE: st_nxt.cfg.filter_rate =
          req.wdata | `FILTER_RATE_RO_MASK;
        `OFS_POWER_STATE: st_nxt.cfg.power_state = req.wdata;
        `OFS_INT_ENABLES: st_nxt.cfg.int_enables =
          req.wdata & `INT_ENABLES_MASK; // see R10
        `OFS_IRQ_PIN_ELEC: st_nxt.cfg.irq_pin_elec =
          req.wdata & `IRQ_PIN_ELEC_MASK;
        `OFS_RESTART: begin
          if (req.wdata == `RESTART_KEY) begin
            st_nxt.restart_pend = 1'b1; // see R11
            st_nxt.restart_cnt = '0;
          end
        end
        default: begin
        end
      endcase
    end

    // Restart completes after the delay, from any mode
    if (st_r.restart_pend) begin
      if (st_r.restart_cnt >= RESTART_DELAY - 1) begin
        st_nxt.restart_pend = 1'b0;
        st_nxt.cfg.full_scale = `RST_FULL_SCALE; // see R11
        st_nxt.cfg.filter_rate = `RST_FILTER_RATE;
        st_nxt.cfg.power_state = `RST_POWER_STATE;
        st_nxt.cfg.int_enables = `RST_INT_ENABLES; // see R10
        st_nxt.cfg.irq_pin_elec = `RST_IRQ_PIN_ELEC;
      end else begin
        st_nxt.restart_cnt = st_r.restart_cnt + 32'h1;
      end
    end

    // Read data; unmapped offsets read zero
    st_nxt.rdata = 8'h00; // see R12
    if (req.rd) begin
      unique case (req.addr)
        `OFS_IDENT: st_nxt.rdata = IDENT_VALUE; // see R1
        `OFS_RATE_X_LOW: st_nxt.rdata = shown_v[2][7:0]; // see R2
        `OFS_RATE_X_HIGH: st_nxt.rdata = st_r.high_locked[2] ?
          st_r.high_hold[2] : shown_v[2][15:8]; // see R4
        `OFS_RATE_Y_LOW: st_nxt.rdata = shown_v[1][7:0]; // see R2
        `OFS_RATE_Y_HIGH: st_nxt.rdata = st_r.high_locked[1] ?
          st_r.high_hold[1] : shown_v[1][15:8]; // see R4
        `OFS_RATE_Z_LOW: st_nxt.rdata = shown_v[0][7:0]; // see R2
        `OFS_RATE_Z_HIGH: st_nxt.rdata = st_r.high_locked[0] ?
          st_r.high_hold[0] : shown_v[0][15:8]; // see R4
        `OFS_INT_FLAGS: begin
          st_nxt.rdata[`BIT_DRDY] = st_r.drdy; // see R6
          st_nxt.rdata[`BIT_FIFO_INT] = st_r.fifo_int; // see R6
        end
        `OFS_QUEUE_FILL: st_nxt.rdata =
          {st_r.overrun, st_r.frames}; // see R8
        `OFS_FULL_SCALE: st_nxt.rdata = st_r.cfg.full_scale;
        `OFS_FILTER_RATE: st_nxt.rdata = st_r.cfg.filter_rate;
        `OFS_POWER_STATE: st_nxt.rdata = st_r.cfg.power_state;
        `OFS_INT_ENABLES: st_nxt.rdata = st_r.cfg.int_enables;
        `OFS_IRQ_PIN_ELEC: st_nxt.rdata = st_r.cfg.irq_pin_elec;
        default: st_nxt.rdata = 8'h00; // see R12
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      st_r <= '0;
      st_r.cfg.full_scale <= `RST_FULL_SCALE;
      st_r.cfg.filter_rate <= `RST_FILTER_RATE;
      st_r.cfg.power_state <= `RST_POWER_STATE;
      st_r.cfg.int_enables <= `RST_INT_ENABLES;
      st_r.cfg.irq_pin_elec <= `RST_IRQ_PIN_ELEC;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign rdata = st_r.rdata;
  assign cfg = st_r.cfg;
  // Core drops its stored frames on this write
  assign fifo_config_clear = cfg1_wr; // see R9

endmodule : gyro_register_readout

/* File: verification/gyro_host_model.sv */
`timescale 1ns/1ps
module gyro_host_model (
  // Bus
  input wire logic clk_sys,
  output gyro_readout_pkg::reg_req_s req,
  input wire logic [7:0] rdata
);
  initial req = '0;
  // Released address and data are inverted and strobes cleared so stale values never look valid
  task automatic acc(input logic w, input logic [7:0] a, d,
                     output logic [7:0] q);
    @(posedge clk_sys);
    req <= '{addr: a, wdata: d, wr: w, rd: !w};
    @(posedge clk_sys);
    req <= '{addr: ~a, wdata: ~d, wr: 1'b0, rd: 1'b0};
    #1 q = rdata;
  endtask : acc
endmodule : gyro_host_model

/* File: verification/gyro_readout_checker.sv */
`timescale 1ns/1ps
module gyro_readout_checker #(
  parameter logic [7:0] IDENT_VALUE = 8'h5a, // Arbitrary value
  parameter int unsigned DRDY_HOLD = 20,
  parameter int unsigned RESTART_DELAY = 50
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic arst_n,
  // Register access
  input wire gyro_readout_pkg::reg_req_s req,
  input wire logic [7:0] rdata,
  // Sensor core side
  input wire logic sample_valid,
  input wire logic fifo_overrun_event,
  input wire gyro_readout_pkg::cfg_s cfg,
  input wire logic fifo_config_clear
);
  localparam int RST_MAX = RESTART_DELAY + 2;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!arst_n);
  AST_IDENT: assert property (req.rd && req.addr == 8'h00 |=>
    rdata == IDENT_VALUE) else $error("Bad identification");
  AST_RSVD: assert property (req.rd &&
    req.addr inside {8'h01, 8'h0c, 8'h13} |=> rdata == 8'h00)
    else $error("Reserved read not zero");
  AST_RD_IDLE: assert property (!req.rd |=> rdata == 8'h00)
    else $error("Read data not idle");
  AST_WR_EN: assert property (req.wr && req.addr == 8'h15 |=>
    cfg.int_enables == ($past(req.wdata) & 8'hc0)) else $error("Enables");
  AST_CFG1: assert property (fifo_config_clear ==
    (req.wr && req.addr == 8'h3e)) else $error("Config clear pulse");
  AST_RESTART: assert property (req.wr && req.addr == 8'h14 &&
    req.wdata == 8'hb6 |-> ##[1:RST_MAX] cfg == 40'h008000000f)
    else $error("Restart did not restore");
  AST_OVR: assert property (fifo_overrun_event ##1 (req.rd &&
    req.addr == 8'h0e && !fifo_config_clear) |=> rdata[7])
    else $error("Overrun flag missing");
  AST_DRDY: assert property (sample_valid ##1 (req.rd &&
    req.addr == 8'h0a) |=> rdata[7]) else $error("Data ready missing");
  cover property (req.rd && req.addr == 8'h02);
  cover property (fifo_overrun_event);
  cover property (req.wr && req.addr == 8'h14 && req.wdata == 8'hb6);
endmodule : gyro_readout_checker
bind gyro_register_readout gyro_readout_checker #(
  .IDENT_VALUE(IDENT_VALUE), .DRDY_HOLD(DRDY_HOLD),
  .RESTART_DELAY(RESTART_DELAY)) chk_u (.clk_sys(clk_sys),
  .arst_n(arst_n), .req(req), .rdata(rdata), .sample_valid(sample_valid),
  .fifo_overrun_event(fifo_overrun_event), .cfg(cfg),
  .fifo_config_clear(fifo_config_clear));

/* File: verification/gyro_register_readout_tb.sv */
`timescale 1ns/1ps
module gyro_register_readout_tb;
  logic clk_sys = 1'b0;
  logic arst_n = 1'b0;
  gyro_readout_pkg::reg_req_s req;
  logic [7:0] rdata;
  logic sample_valid = 1'b0;
  gyro_readout_pkg::rate_set_s sample = '0;
  logic fifo_event = 1'b0;
  logic fifo_overrun_event = 1'b0;
  logic push = 1'b0;
  logic pop = 1'b0;
  logic [7:0] q;
  int n_fail = 0;
  int n_compared = 0;
  always #2.5 clk_sys = ~clk_sys;
  gyro_register_readout #(.DRDY_HOLD(20), .RESTART_DELAY(50)) dut_u (
    .clk_sys(clk_sys), .arst_n(arst_n), .req(req), .rdata(rdata),
    .sample_valid(sample_valid), .sample(sample), .fifo_event(fifo_event),
    .fifo_overrun_event(fifo_overrun_event), .fifo_frame_push(push),
    .fifo_frame_pop(pop), .cfg(), .fifo_config_clear());
  gyro_host_model host_u (.clk_sys(clk_sys), .req(req), .rdata(rdata));
  task automatic chk(input logic [15:0] seen, exp);
    n_compared++;
    if (seen !== exp) begin
      n_fail++;
      $display("Error at %0t: got %h want %h", $time, seen, exp);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, d);
    host_u.acc(1'b1, a, d, q);
  endtask : wr
  task automatic rdc(input logic [7:0] a, e);
    host_u.acc(1'b0, a, 8'h00, q);
    chk(q, e);
  endtask : rdc
  task automatic put(input logic [47:0] s);
    @(posedge clk_sys);
    sample <= s;
    sample_valid <= 1'b1;
    @(posedge clk_sys);
    sample_valid <= 1'b0;
  endtask : put
  task automatic t_reset;
    logic [7:0] a[7] = '{8'h00, 8'h01, 8'h0f, 8'h10, 8'h11, 8'h15, 8'h16};
    logic [7:0] e[7] = '{8'h5a, 8'h00, 8'h00, 8'h80, 8'h00, 8'h00, 8'h0f};
    wr(8'h00, 8'hff);
    for (int i = 0; i < 7; i++) rdc(a[i], e[i]);
  endtask : t_reset
  task automatic t_lock;
    logic [47:0] va = 48'h7fff_8001_0000;
    logic [47:0] vb = 48'h1234_5678_9abc;
    logic [7:0] lo;
    for (int i = 0; i < 3; i++) begin
      put(va);
      host_u.acc(1'b0, 8'(2 + 2 * i), 8'h00, lo);
      put(vb);
      host_u.acc(1'b0, 8'(3 + 2 * i), 8'h00, q);
      chk(16'(q * 256 + lo), va[47 - 16 * i -: 16]);
      host_u.acc(1'b0, 8'(2 + 2 * i), 8'h00, lo);
      host_u.acc(1'b0, 8'(3 + 2 * i), 8'h00, q);
      chk(16'(q * 256 + lo), vb[47 - 16 * i -: 16]);
    end
  endtask : t_lock
  task automatic t_flags;
    put(48'h0);
    rdc(8'h0a, 8'h80);
    repeat (25) @(posedge clk_sys);
    rdc(8'h0a, 8'h00);
    @(posedge clk_sys) fifo_event <= 1'b1;
    rdc(8'h0a, 8'h10);
    @(posedge clk_sys) fifo_event <= 1'b0;
  endtask : t_flags
  task automatic t_fifo;
    @(posedge clk_sys) push <= 1'b1;
    repeat (3) @(posedge clk_sys);
    push <= 1'b0;
    rdc(8'h0e, 8'h03);
    @(posedge clk_sys) fifo_overrun_event <= 1'b1;
    @(posedge clk_sys) fifo_overrun_event <= 1'b0;
    rdc(8'h0e, 8'h83);
    @(posedge clk_sys) pop <= 1'b1;
    repeat (3) @(posedge clk_sys);
    pop <= 1'b0;
    rdc(8'h0e, 8'h80);
    wr(8'h3e, 8'h00);
    rdc(8'h0e, 8'h00);
  endtask : t_fifo
  task automatic t_restart;
    wr(8'h15, 8'hc0);
    wr(8'h14, 8'h12);
    repeat (55) @(posedge clk_sys);
    rdc(8'h15, 8'hc0);
    wr(8'h14, 8'hb6);
    repeat (55) @(posedge clk_sys);
    rdc(8'h15, 8'h00);
  endtask : t_restart
  task automatic final_report;
    $display("Compared %0d, failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : final_report
  initial begin
    repeat (2) @(posedge clk_sys);
    arst_n <= 1'b1;
    t_reset;
    t_lock;
    t_flags;
    t_fifo;
    t_restart;
    final_report;
  end
endmodule : gyro_register_readout_tb
